// [core/dmp_map.svh]
// Purpose: Timing counts for the dual asynchronous memory port controller.
// Assumes: sys_clk at 25 MHz, 40 ns period.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef DMP_MAP_SVH
`define DMP_MAP_SVH

`define DMP_CLK_PERIOD_NS      40
`define DMP_POWERUP_US         200
`define DMP_POWERUP_CYC        ((`DMP_POWERUP_US * 1000 + `DMP_CLK_PERIOD_NS - 1) / `DMP_CLK_PERIOD_NS)
`define DMP_BREAK_US           4
`define DMP_BREAK_CYC          ((`DMP_BREAK_US * 1000) / `DMP_CLK_PERIOD_NS)
`define DMP_READ_CYCLE_NS      100
`define DMP_READ_CYCLE_CYC     ((`DMP_READ_CYCLE_NS + `DMP_CLK_PERIOD_NS - 1) / `DMP_CLK_PERIOD_NS)
`define DMP_WRITE_FAST_NS      80
`define DMP_WRITE_FAST_CYC     ((`DMP_WRITE_FAST_NS + `DMP_CLK_PERIOD_NS - 1) / `DMP_CLK_PERIOD_NS)
`define DMP_WRITE_SLOW_NS      100
`define DMP_WRITE_SLOW_CYC     ((`DMP_WRITE_SLOW_NS + `DMP_CLK_PERIOD_NS - 1) / `DMP_CLK_PERIOD_NS)
`define DMP_FAST_BURST_MAX     20
`define DMP_WARM_READS         2

`endif

// [core/dmp_pkg.sv]
// Purpose: Types for the dual asynchronous memory port controller.
// Assumes: Nothing beyond the map header.
// Notes:   States Gray-coded along the usual path.
package dmp_pkg;
	typedef enum logic [2:0] {
		DMP_POWERUP = 3'b000,
		DMP_WARM    = 3'b001,
		DMP_IDLE    = 3'b011,
		DMP_SETUP   = 3'b010,
		DMP_STROBE  = 3'b110,
		DMP_RECOVER = 3'b111,
		DMP_BREAK   = 3'b101
	} dmp_state_t;
endpackage

// [core/dmp_counter.sv]
// Purpose: Down counter used for every timed phase of the controller.
// Assumes: Load has priority over counting.
// Notes:   done is high while the count is zero.
`timescale 1ns/1ps
`default_nettype none
module dmp_counter (
	input  wire logic        sys_clk, // Clock
	input  wire logic        rst_n,   // Asynchronous reset, active low
	input  wire logic        load,    // Load a new count
	input  wire logic [15:0] value,   // Count to load
	output logic             done     // Count reached zero
);
	logic [15:0] count;

	// Load or count down towards zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			count <= 16'h0000;
		else if (load)
			count <= value;
		else if (count != 16'h0000)
			count <= count - 16'h0001;
	end

	assign done = (count == 16'h0000);
endmodule
`default_nettype wire

// [core/dmp_ctrl.sv]
// Purpose: Host-side controller for a two-die package (pseudo-static and static RAM).
// Assumes: One request at a time; pins driven from flip-flops on sys_clk.
// Notes:   Data bus is split into in, out and an active-low output enable.
`timescale 1ns/1ps
`default_nettype none
`include "dmp_map.svh"

// Function
// R1 - Pseudo-static write happens only while its select and write enable both low.
// R2 - Write starts with select, write enable low and one or both byte enables.
// R3 - Pseudo-static die ends a write at first rise of select or write enable.
// R4 - Static die frames writes the same way with its active-low select.
// R5 - Select-to-end-of-write measured from select falling to the write end.
// R6 - Address is valid and stable from set-up until the write begins.
// R7 - Address held stable through write recovery after the write ends.
// R8 - Pseudo-static read cycle is the later of address and select bounds.
// R9 - Dies float the shared bus before another die drives it.
// R10 - Fast write timing only up to 20 back-to-back writes, else slow.
// R11 - Keep pseudo-static select high 200 us after power-up before access.
// R12 - After the power-up wait, do at least two reads before normal use.
// R13 - Pseudo-static die inserts no wait states; precharge hidden.
// R14 - Pseudo-static die refreshes internally with no host action.
// R15 - Device never stalls; host has no hold-off input.
// R16 - Break non-read activity every 4 us with read or select high.
// R17 - Long write runs get a select-high gap every 4 us.
// R18 - Alternatively raise write enable for one read cycle every 4 us.
// R19 - Deep power down loses pseudo-static contents until rewritten.
// R20 - Select at most one die at a time so one drives the bus.
module dmp_ctrl
	import dmp_pkg::*;
(
	input  wire logic        sys_clk,                 // Clock, 25 MHz
	input  wire logic        rst_n,                   // Asynchronous reset, active low
	input  wire logic        req_valid,               // Request present
	output logic             req_ready,               // Request taken this cycle
	input  wire logic        req_write,               // 1 write, 0 read
	input  wire logic        req_sram,                // 1 static die, 0 pseudo-static die
	input  wire logic [20:0] req_addr,                // Word address
	input  wire logic [15:0] req_wdata,               // Write data
	input  wire logic [1:0]  req_be,                  // Byte enables, bit1 high byte
	input  wire logic        sleep_req,               // Request deep power down
	output logic             rsp_valid,               // Read data valid pulse
	output logic [15:0]      rsp_rdata,               // Read data
	output logic             mem_ready,               // Power-up and warm-up complete
	output logic [20:0]      mem_addr,                // Shared address
	input  wire logic [15:0] mem_dq_in,               // Shared data in
	output logic [15:0]      mem_dq_out,              // Shared data out
	output logic             mem_dq_oe_n,             // Data drive enable, low drives
	output logic             mem_write_n,             // Shared write enable
	output logic             mem_read_n,              // Shared output enable
	output logic             psram_select_n,          // Pseudo-static select
	output logic             psram_sleep_n,           // Pseudo-static deep power down
	output logic             psram_high_byte_n,       // Pseudo-static high byte enable
	output logic             psram_low_byte_n,        // Pseudo-static low byte enable
	output logic             sram_select_active_low,  // Static select, active low
	output logic             sram_select_active_high, // Static select, active high
	output logic             sram_high_byte_n,        // Static high byte enable
	output logic             sram_low_byte_n          // Static low byte enable
);
	dmp_state_t  state;
	dmp_state_t  next_state;
	logic        cur_write;
	logic        cur_sram;
	logic [1:0]  cur_be;
	logic [4:0]  burst_len;
	logic [1:0]  warm_cnt;
	logic [15:0] run_cnt;
	logic        load;
	logic [15:0] load_val;
	logic        done;
	logic        strobe_on;
	logic        fast_ok;
	logic        break_due;
	logic        up_armed;

	dmp_counter u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.load    (load),
		.value   (load_val),
		.done    (done)
	);

	// Fast timing allowed while the write burst stays within its limit
	assign fast_ok   = (burst_len < 5'(`DMP_FAST_BURST_MAX)); // R10
	assign break_due = (run_cnt >= 16'(`DMP_BREAK_CYC));      // R16 R17
	assign req_ready = (state == DMP_IDLE) && req_valid && !break_due && !sleep_req;

	// Next state; device never stalls, so phases are pure time counts
	always_comb begin
		next_state = state;
		load       = 1'b0;
		load_val   = 16'h0000;
		case (state)
			DMP_POWERUP: begin
				if (!up_armed || !psram_sleep_n) begin
					load       = 1'b1; // R11
					load_val   = 16'(`DMP_POWERUP_CYC);
				end else if (done) begin // R11
					next_state = DMP_SETUP;
					load       = 1'b1;
					load_val   = 16'h0001;
				end
			end
			DMP_WARM: begin
				next_state = (warm_cnt >= 2'(`DMP_WARM_READS)) ? DMP_IDLE : DMP_SETUP; // R12
				load       = 1'b1;
				load_val   = 16'h0001;
			end
			DMP_IDLE: begin
				if (sleep_req) begin
					next_state = DMP_POWERUP; // R19
					load       = 1'b1;
					load_val   = 16'(`DMP_POWERUP_CYC);
				end else if (break_due) begin
					next_state = DMP_BREAK; // R17 R18
					load       = 1'b1;
					load_val   = 16'(`DMP_READ_CYCLE_CYC);
				end else if (req_valid) begin
					next_state = DMP_SETUP;
					load       = 1'b1;
					load_val   = 16'h0001; // R6
				end
			end
			DMP_SETUP: begin
				if (done) begin
					next_state = DMP_STROBE;
					load       = 1'b1;
					if (!cur_write)
						load_val = 16'(`DMP_READ_CYCLE_CYC) - 16'h0001; // R8
					else if (fast_ok)
						load_val = 16'(`DMP_WRITE_FAST_CYC) - 16'h0001; // R5
					else
						load_val = 16'(`DMP_WRITE_SLOW_CYC) - 16'h0001; // R10
				end
			end
			DMP_STROBE: begin
				if (done) begin
					next_state = DMP_RECOVER;
					load       = 1'b1;
					load_val   = 16'h0000;
				end
			end
			DMP_RECOVER: begin
				next_state = mem_ready ? DMP_IDLE : DMP_WARM; // R7
			end
			DMP_BREAK: begin
				if (done)
					next_state = DMP_IDLE;
			end
			default: begin
				next_state = DMP_POWERUP;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			state <= DMP_POWERUP;
		else
			state <= next_state;
	end

	// Power-up wait armed once the full count is loaded; reset leaves the timer at zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			up_armed <= 1'b0;
		else
			up_armed <= (state == DMP_POWERUP) && psram_sleep_n; // R11
	end

	// Latch the request at acceptance; warm-up reads target the pseudo-static die
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_write <= 1'b0;
			cur_sram  <= 1'b0;
			cur_be    <= 2'b00;
		end else if (req_ready) begin
			cur_write <= req_write;
			cur_sram  <= req_sram;
			cur_be    <= req_be;
		end else if (state == DMP_POWERUP || state == DMP_WARM) begin
			cur_write <= 1'b0;
			cur_sram  <= 1'b0;
			cur_be    <= 2'b11;
		end
	end

	// Address and write data held from set-up through recovery
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr   <= 21'h000000;
			mem_dq_out <= 16'h0000;
		end else if (req_ready) begin
			mem_addr   <= req_addr; // R6 R7
			mem_dq_out <= req_wdata;
		end else if (state == DMP_POWERUP) begin
			mem_addr   <= 21'h000000;
		end
	end

	// Warm-up read count and ready flag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			warm_cnt  <= 2'b00;
			mem_ready <= 1'b0;
		end else if (state == DMP_POWERUP) begin
			warm_cnt  <= 2'b00;
			mem_ready <= 1'b0;
		end else if (state == DMP_RECOVER && !mem_ready) begin
			warm_cnt <= warm_cnt + 2'b01; // R12
		end else if (state == DMP_WARM && next_state == DMP_IDLE) begin
			mem_ready <= 1'b1;
		end
	end

	// Back-to-back write count; any read or break resets it, idle gaps do not
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			burst_len <= 5'h00;
		else if (state == DMP_RECOVER && cur_write && burst_len != 5'h1F)
			burst_len <= burst_len + 5'h01; // R10
		else if (state == DMP_BREAK || (state == DMP_RECOVER && !cur_write))
			burst_len <= 5'h00;
	end

	// Time spent without a completed read or a select-high gap
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			run_cnt <= 16'h0000;
		else if (state == DMP_BREAK || state == DMP_POWERUP)
			run_cnt <= 16'h0000; // R16 R18
		else if (state == DMP_RECOVER && !cur_write)
			run_cnt <= 16'h0000; // R16
		else if (state == DMP_IDLE && !req_valid)
			run_cnt <= 16'h0000;
		else if (!break_due)
			run_cnt <= run_cnt + 16'h0001;
	end

	// Strobe window; one die at a time, selects stay inactive in break and power-up
	assign strobe_on = (state == DMP_STROBE);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			psram_select_n          <= 1'b1; // R11
			sram_select_active_low  <= 1'b1;
			sram_select_active_high <= 1'b0;
			psram_high_byte_n       <= 1'b1;
			psram_low_byte_n        <= 1'b1;
			sram_high_byte_n        <= 1'b1;
			sram_low_byte_n         <= 1'b1;
			mem_write_n             <= 1'b1;
			mem_read_n              <= 1'b1;
			mem_dq_oe_n             <= 1'b1;
		end else begin
			psram_select_n          <= !(next_state == DMP_STROBE && !cur_sram); // R20 R1 R3
			sram_select_active_low  <= !(next_state == DMP_STROBE && cur_sram);  // R4 R20
			sram_select_active_high <= (next_state == DMP_STROBE && cur_sram);
			psram_high_byte_n       <= !(next_state == DMP_STROBE && !cur_sram && cur_be[1]); // R2
			psram_low_byte_n        <= !(next_state == DMP_STROBE && !cur_sram && cur_be[0]);
			sram_high_byte_n        <= !(next_state == DMP_STROBE && cur_sram && cur_be[1]);
			sram_low_byte_n         <= !(next_state == DMP_STROBE && cur_sram && cur_be[0]);
			mem_write_n             <= !(next_state == DMP_STROBE && cur_write); // R1 R18
			mem_read_n              <= !(next_state == DMP_STROBE && !cur_write); // R9
			mem_dq_oe_n             <= !((next_state == DMP_STROBE || next_state == DMP_RECOVER)
				&& cur_write && state != DMP_IDLE);
		end
	end

	// Deep power down pin, released when waking from sleep
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			psram_sleep_n <= 1'b1;
		else if (state == DMP_IDLE && sleep_req)
			psram_sleep_n <= 1'b0; // R19
		else if (!sleep_req)
			psram_sleep_n <= 1'b1;
	end

	// Capture read data at the end of the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= strobe_on && done && !cur_write && mem_ready;
			if (strobe_on && done && !cur_write)
				rsp_rdata <= mem_dq_in;
		end
	end
endmodule
`default_nettype wire

// [test/dmp_ctrl_sva.sv]
// Purpose: Port assertions for dmp_ctrl.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every dmp_ctrl instance below.
`timescale 1ns/1ps
`default_nettype none
module dmp_ctrl_sva (
	input wire logic        sys_clk,                 // Clock
	input wire logic        rst_n,                   // Reset
	input wire logic        req_valid,               // Request
	input wire logic        req_ready,               // Taken
	input wire logic        req_write,               // Write
	input wire logic        rsp_valid,               // Read done
	input wire logic        mem_ready,               // Ready
	input wire logic [20:0] mem_addr,                // Address
	input wire logic        mem_write_n,             // Write strobe
	input wire logic        mem_read_n,              // Read strobe
	input wire logic        psram_select_n,          // Select
	input wire logic        psram_sleep_n,           // Sleep
	input wire logic        sram_select_active_low,  // Select
	input wire logic        sram_select_active_high  // Select
);
	localparam logic [12:0] QUIET_CYC = 13'h1384; // 5000 less 4 cycles slack
	logic [12:0] up_cnt;  // Cycles since reset or wake
	logic [1:0]  rd_cnt;  // Warm read strobes
	logic [7:0]  low_cnt; // Cycles with select low
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Power-up, warm-read and select-low counters
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt <= '0;
			rd_cnt <= '0;
			low_cnt <= '0;
		end else begin
			up_cnt <= !psram_sleep_n ? '0 : (&up_cnt ? up_cnt : up_cnt + 13'h1);
			rd_cnt <= !psram_sleep_n ? '0 : (rd_cnt == 2'h2 ? rd_cnt :
				rd_cnt + {1'b0, $fell(mem_read_n) && !psram_select_n});
			low_cnt <= psram_select_n ? '0 : low_cnt + 8'h1;
		end
	end
	a_one_die_only: assert property (!(!psram_select_n && !sram_select_active_low
		&& sram_select_active_high)) else $error("Both dies selected");
	a_powerup_quiet: assert property (up_cnt < QUIET_CYC |-> psram_select_n)
		else $error("Select low during power-up wait");
	a_warm_reads_done: assert property ($rose(mem_ready) |-> rd_cnt == 2'h2)
		else $error("Ready before two reads");
	a_take_when_ready: assert property (req_ready |-> mem_ready)
		else $error("Request taken before ready");
	a_write_has_select: assert property (!mem_write_n |->
		(!psram_select_n || !sram_select_active_low)) else $error("Write without select");
	a_addr_setup_held: assert property ($fell(mem_write_n) |-> $stable(mem_addr))
		else $error("Address moved at write start");
	a_addr_recovery: assert property (!mem_write_n |=> $stable(mem_addr))
		else $error("Address moved before write end");
	a_write_min_width: assert property ($fell(mem_write_n) |-> !mem_write_n[*2])
		else $error("Write strobe too short");
	a_read_cycle_len: assert property ($fell(mem_read_n) |-> !mem_read_n[*3])
		else $error("Read strobe too short");
	a_read_answer_time: assert property (req_valid && req_ready && !req_write |-> ##6 rsp_valid)
		else $error("Read answer late or early");
	a_select_breaks: assert property (low_cnt <= 8'h64)
		else $error("Select low beyond break interval");
	c_ready: cover property ($rose(mem_ready));
	c_read: cover property (rsp_valid);
	c_slow_write: cover property ($fell(mem_write_n) ##2 !mem_write_n);
endmodule
bind dmp_ctrl dmp_ctrl_sva dmp_ctrl_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
	.rsp_valid(rsp_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
	.mem_write_n(mem_write_n), .mem_read_n(mem_read_n), .psram_select_n(psram_select_n),
	.psram_sleep_n(psram_sleep_n), .sram_select_active_low(sram_select_active_low),
	.sram_select_active_high(sram_select_active_high));
`default_nettype wire

// [test/dmp_mem_model.sv]
// Purpose: Behavioural two-die memory at the far side of dmp_ctrl.
// Assumes: Only the low 8 address bits decode.
// Notes:   A bus nobody drives shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module dmp_mem_model (
	input  wire logic        sys_clk,                 // Clock
	input  wire logic [20:0] mem_addr,                // Address
	input  wire logic [15:0] mem_dq_out,              // Host data
	input  wire logic        mem_dq_oe_n,             // Host drives when low
	input  wire logic        mem_write_n,             // Write strobe
	input  wire logic        mem_read_n,              // Read strobe
	input  wire logic        psram_select_n,          // Select
	input  wire logic        psram_sleep_n,           // Sleep
	input  wire logic        psram_high_byte_n,       // High byte
	input  wire logic        psram_low_byte_n,        // Low byte
	input  wire logic        sram_select_active_low,  // Select
	input  wire logic        sram_select_active_high, // Select
	input  wire logic        sram_high_byte_n,        // High byte
	input  wire logic        sram_low_byte_n,         // Low byte
	output logic      [15:0] mem_dq_in                // Bus level
);
	logic [15:0] u_mem [256]; // Contents kept with no host action
	logic [15:0] s_mem [256];
	logic [15:0] last;
	logic [15:0] bm;
	logic [15:0] wd;
	wire u_on = !psram_select_n && psram_sleep_n && !(psram_high_byte_n && psram_low_byte_n);
	wire s_on = !sram_select_active_low && sram_select_active_high
		&& !(sram_high_byte_n && sram_low_byte_n);
	// Byte mask of the selected die and the data on the bus
	assign bm = u_on ? {{8{!psram_high_byte_n}}, {8{!psram_low_byte_n}}}
		: {{8{!sram_high_byte_n}}, {8{!sram_low_byte_n}}};
	assign wd = mem_dq_oe_n ? ~last : mem_dq_out;
	// Store only while select and write enable are both low
	always @(posedge sys_clk) begin
		if (!psram_sleep_n)
			foreach (u_mem[k]) u_mem[k] = ~u_mem[k];
		if (u_on && !mem_write_n)
			u_mem[mem_addr[7:0]] = (u_mem[mem_addr[7:0]] & ~bm) | (wd & bm);
		if (s_on && !mem_write_n)
			s_mem[mem_addr[7:0]] = (s_mem[mem_addr[7:0]] & ~bm) | (wd & bm);
		last <= mem_dq_in;
	end
	// Drive only while reading; otherwise float
	assign mem_dq_in = (u_on && !mem_read_n && mem_write_n) ? u_mem[mem_addr[7:0]]
		: (s_on && !mem_read_n && mem_write_n) ? s_mem[mem_addr[7:0]] : ~last;
endmodule
`default_nettype wire

// [test/dmp_ctrl_tb.sv]
// Purpose: Self-checking bench for dmp_ctrl with a two-die model.
// Assumes: 25 MHz clock; inputs move 1 ns after the rising edge.
// Notes:   Full 5000-cycle power-up wait, run twice.
`timescale 1ns/1ps
`default_nettype none
module dmp_ctrl_tb;
	logic        sys_clk, rst_n, req_valid, req_ready, req_write, req_sram;
	logic        sleep_req, rsp_valid, mem_ready, oe_n, wr_n, rd_n;
	logic        u_sel_n, u_slp_n, u_hi_n, u_lo_n, s_sel_n, s_sel, s_hi_n, s_lo_n;
	logic [20:0] req_addr, mem_addr;
	logic [15:0] req_wdata, rsp_rdata, dq_in, dq_out, got;
	logic [1:0]  req_be;
	int          bad_count, samples_checked, wlen, last_w, i;
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Length of each write strobe in cycles
	always @(posedge sys_clk) begin
		if (wr_n === 1'b0)
			wlen++;
		else if (wlen != 0) begin
			last_w = wlen;
			wlen = 0;
		end
	end
	dmp_ctrl dmp_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_sram(req_sram), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_be(req_be), .sleep_req(sleep_req), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_dq_in(dq_in),
		.mem_dq_out(dq_out), .mem_dq_oe_n(oe_n), .mem_write_n(wr_n), .mem_read_n(rd_n),
		.psram_select_n(u_sel_n), .psram_sleep_n(u_slp_n), .psram_high_byte_n(u_hi_n),
		.psram_low_byte_n(u_lo_n), .sram_select_active_low(s_sel_n),
		.sram_select_active_high(s_sel), .sram_high_byte_n(s_hi_n), .sram_low_byte_n(s_lo_n));
	dmp_mem_model dmp_mem_model_i (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_dq_out(dq_out),
		.mem_dq_oe_n(oe_n), .mem_write_n(wr_n), .mem_read_n(rd_n), .psram_select_n(u_sel_n),
		.psram_sleep_n(u_slp_n), .psram_high_byte_n(u_hi_n), .psram_low_byte_n(u_lo_n),
		.sram_select_active_low(s_sel_n), .sram_select_active_high(s_sel),
		.sram_high_byte_n(s_hi_n), .sram_low_byte_n(s_lo_n), .mem_dq_in(dq_in));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait for power-up and warm reads
	task automatic wait_ready;
		for (i = 0; i < 6000 && mem_ready !== 1'b1; i++) @(negedge sys_clk);
		chk("mem_ready", 16'h1, {15'h0, mem_ready});
		if (mem_ready !== 1'b1)
			tally_and_finish;
	endtask
	// One request held until taken; a read leaves its data in got
	task automatic xfer(input logic w, input logic s, input logic [20:0] a,
		input logic [15:0] d, input logic [1:0] be);
		@(posedge sys_clk);
		#1;
		{req_valid, req_write, req_sram, req_addr, req_wdata, req_be} = {1'b1, w, s, a, d, be};
		@(negedge sys_clk);
		for (i = 0; i < 6000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
		if (req_ready !== 1'b1) begin
			chk("req_ready", 16'h1, {15'h0, req_ready});
			tally_and_finish;
		end
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		for (i = 0; i < 20 && !w && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
		got = (rsp_valid === 1'b1) ? rsp_rdata : 'x;
	endtask
	task automatic t_powerup;
		repeat (4000) @(negedge sys_clk);
		chk("early ready", 16'h0, {15'h0, mem_ready});
		chk("early select", 16'h1, {15'h0, u_sel_n});
		wait_ready;
	endtask
	task automatic t_two_dies;
		xfer(1'b1, 1'b0, 21'h5, 16'hA5A5, 2'h3);
		xfer(1'b1, 1'b1, 21'h5, 16'h5A5A, 2'h3);
		xfer(1'b0, 1'b0, 21'h5, 16'h0, 2'h3);
		chk("pseudo-static word", 16'hA5A5, got);
		xfer(1'b0, 1'b1, 21'h5, 16'h0, 2'h3);
		chk("static word", 16'h5A5A, got);
	endtask
	task automatic t_byte_lanes;
		xfer(1'b1, 1'b0, 21'h9, 16'h1234, 2'h3);
		xfer(1'b1, 1'b0, 21'h9, 16'hABCD, 2'h1);
		xfer(1'b1, 1'b1, 21'h9, 16'h1234, 2'h3);
		xfer(1'b1, 1'b1, 21'h9, 16'hABCD, 2'h2);
		xfer(1'b0, 1'b0, 21'h9, 16'h0, 2'h3);
		chk("low byte write", 16'h12CD, got);
		xfer(1'b0, 1'b1, 21'h9, 16'h0, 2'h3);
		chk("high byte write", 16'hAB34, got);
	endtask
	task automatic t_burst;
		xfer(1'b1, 1'b0, 21'h40, 16'h40, 2'h3);
		repeat (7) @(negedge sys_clk);
		chk("first strobe", 16'h2, 16'(last_w));
		for (int k = 1; k < 26; k++) xfer(1'b1, 1'b0, 21'h40 + 21'(k), 16'(k + 64), 2'h3);
		xfer(1'b0, 1'b0, 21'h59, 16'h0, 2'h3);
		chk("burst tail", 16'h59, got);
		chk("last strobe", 16'h2, 16'(last_w));
		// Spaced writes keep the activity timer clear, so the 21st write runs slow
		for (int k = 1; k < 21; k++) begin
			xfer(1'b1, 1'b0, 21'h60, 16'(k), 2'h3);
			repeat (7) @(negedge sys_clk);
		end
		chk("20th strobe", 16'h2, 16'(last_w));
		xfer(1'b1, 1'b0, 21'h60, 16'h21, 2'h3);
		repeat (7) @(negedge sys_clk);
		chk("21st strobe", 16'h3, 16'(last_w));
		xfer(1'b0, 1'b0, 21'h60, 16'h0, 2'h3);
		chk("slow write data", 16'h21, got);
	endtask
	task automatic t_sleep;
		@(posedge sys_clk);
		#1;
		sleep_req = 1'b1;
		repeat (10) @(negedge sys_clk);
		chk("sleep pin", 16'h0, {15'h0, u_slp_n});
		chk("ready in sleep", 16'h0, {15'h0, req_ready});
		@(posedge sys_clk);
		#1;
		sleep_req = 1'b0;
		wait_ready;
		xfer(1'b1, 1'b0, 21'h3, 16'hC3C3, 2'h3);
		xfer(1'b0, 1'b0, 21'h3, 16'h0, 2'h3);
		chk("after wake", 16'hC3C3, got);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		{rst_n, req_valid, req_write, req_sram, sleep_req} = '0;
		{req_addr, req_wdata, req_be} = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_powerup;
		t_two_dies;
		t_byte_lanes;
		t_burst;
		t_sleep;
		tally_and_finish;
	end
endmodule
`default_nettype wire
